// ### pkg/bcs_map.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
//Function
//- Gates sit in one of six states, stepped cyclically; each step commutes.
//- States drive A/C, B/C, B/A, C/A, C/B, A/B high/low; third floats.
//- Run bit clear turns every gate off regardless of brake and direction.
//- Run and brake set turn all low sides on, high sides off.
//- On gate: high-side output low, low-side output high.
//- Off gate: high-side output high, low-side output low.
//- Electrical-cycle mode: speed output rises entering state 1, falls entering 4.
//- Commutation-rate mode: square wave, falling edge at each commutation point.
//- Speed output starts in electrical-cycle mode; serial port selects the other.
//- Speed output is open drain: pulls low, releases for high.
//- Fault output is open drain, active low, asserted on any fault.
//- Each serial transfer is one 16-bit word, msb first.
//- Serial input sampled on each rising serial clock edge.
//- Strobe high: ignore clock and data, serial output released.
//- Strobe falling drives diagnostic bit 15, the fault summary, out at once.
//- Position estimator and commutation timer adapt to sensed rotor position.
//- Three serially selectable modes: duty, current and speed control.
//- Control input sets operating state and supplies proportional demand.
//- Fixed off-time current limiter; limit lowered through serial port.
//- One combined fault flag; per-fault detail readable through serial port.
//- Motor speed is the electrical cycle frequency, as the speed output.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_ADDR_CTRL    4'h0
`define BCS_ADDR_PERIOD  4'h4
`define BCS_ADDR_STATUS  4'h8
`define BCS_ADDR_SERWORD 4'hC
`define BCS_CTRL_RUN     0
`define BCS_CTRL_BRAKE   1
`define BCS_CTRL_DIR     2
`define BCS_CTRL_SPDMODE 3
`define BCS_CTRL_OPM_LO  4
`define BCS_CTRL_ILIM_LO 6
`define BCS_CTRL_EXTEN   10
`define BCS_SER_WR       15
`define BCS_SER_SPDMODE  14
`define BCS_SER_OPM_LO   12
`define BCS_SER_ILIM_LO  8
`define BCS_RST_PERIOD   16'h1000
`define BCS_RST_ILIM     4'hF
`define BCS_CLK_MHZ      25
`define BCS_OFF_TIME_NS  50400
`define BCS_OFF_CYCLES   ((`BCS_OFF_TIME_NS * `BCS_CLK_MHZ + 999) / 1000)
`endif

// ### pkg/bcs_pkg.sv
// Types shared by the commutation sequencer
package bcs_pkg;
  typedef enum logic [2:0] {
    BCS_S1 = 3'b000,
    BCS_S2 = 3'b001,
    BCS_S3 = 3'b010,
    BCS_S4 = 3'b011,
    BCS_S5 = 3'b100,
    BCS_S6 = 3'b101
  } bcs_comm_t;
  typedef enum logic [1:0] {
    BCS_OPM_DUTY  = 2'b00,
    BCS_OPM_CURR  = 2'b01,
    BCS_OPM_SPEED = 2'b10
  } bcs_opm_t;
endpackage

// ### src/bcs_top.sv
// Six-state commutation sequencer with serial diagnostics and Wishbone registers
`include "bcs_map.svh"
module bcs_top
  import bcs_pkg::*;
#(
  parameter int PW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          ser_clk_i,
  input  wire logic          ser_in_i,
  input  wire logic          ser_strobe_n_i,
  output logic               ser_out_o,
  output logic               ser_out_oe_o,
  input  wire logic          ctl_in_i,
  input  wire logic          zero_cross_i,
  input  wire logic          ilim_trip_i,
  input  wire logic [3:0]    fault_i,
  output logic               high_gate_a_o,
  output logic               high_gate_b_o,
  output logic               high_gate_c_o,
  output logic               low_gate_a_o,
  output logic               low_gate_b_o,
  output logic               low_gate_c_o,
  output logic               speed_out_o,
  output logic               speed_out_oe_o,
  output logic               fault_out_n_o,
  output logic               fault_out_n_oe_o,
  output logic      [3:0]    ilim_level_o,
  output logic      [1:0]    op_mode_o,
  output logic      [PW-1:0] demand_o
);
  localparam logic [11:0] OFF_CYC = 12'(`BCS_OFF_CYCLES);

  typedef struct packed {
    logic [31:0]   rdat;
    logic          ack;
    logic          run;
    logic          brake;
    logic          dir;
    logic          spd_mode;
    logic [1:0]    opm;
    logic [3:0]    ilim;
    logic          ext_en;
    logic [PW-1:0] period_sw;
    logic [PW-1:0] period;
    logic [PW-1:0] timer;
    logic          zc_seen;
    bcs_comm_t     comm;
    logic          elec_cycle_pulse;
    logic          commutation_square;
    logic [2:0]    hg;
    logic [2:0]    lg;
    logic          spd_oe;
    logic          flt_oe;
    logic [11:0]   off_cnt;
    logic [5:0]    sa;
    logic [5:0]    sb;
    logic [1:0]    sc;
    logic [3:0]    s1f;
    logic [3:0]    s2f;
    logic          sck_d;
    logic          zc_d;
    logic          ctl_d;
    logic          stb_d;
    logic [15:0]   rx;
    logic [15:0]   tx;
    logic [4:0]    bits;
    logic [15:0]   ser_word;
    logic          ser_out;
    logic          sdo_oe;
    logic [3:0]    flt_lat;
    logic [PW-1:0] ctl_cnt;
    logic [PW-1:0] ctl_hi;
    logic [PW-1:0] demand;
  } st_t;

  st_t st;
  st_t next_st;

  // Gate pattern per state: {high a,b,c , low a,b,c}, one means conducting
  function automatic logic [5:0] gate_pat(input bcs_comm_t s);
    case (s)
      BCS_S1:  gate_pat = 6'b100_001;
      BCS_S2:  gate_pat = 6'b010_001;
      BCS_S3:  gate_pat = 6'b010_100;
      BCS_S4:  gate_pat = 6'b001_100;
      BCS_S5:  gate_pat = 6'b001_010;
      BCS_S6:  gate_pat = 6'b100_010;
      default: gate_pat = 6'b000_000;
    endcase
  endfunction

  function automatic bcs_comm_t step(input bcs_comm_t s, input logic down);
    case (s)
      BCS_S1:  step = down ? BCS_S6 : BCS_S2;
      BCS_S2:  step = down ? BCS_S1 : BCS_S3;
      BCS_S3:  step = down ? BCS_S2 : BCS_S4;
      BCS_S4:  step = down ? BCS_S3 : BCS_S5;
      BCS_S5:  step = down ? BCS_S4 : BCS_S6;
      BCS_S6:  step = down ? BCS_S5 : BCS_S1;
      default: step = BCS_S1;
    endcase
  endfunction

  logic          sck;
  logic          ser_in;
  logic          stb_n;
  logic          ctl;
  logic          zc;
  logic          trip;
  logic [3:0]    flt;
  logic          sck_rise;
  logic          sck_fall;
  logic          stb_fall;
  logic          stb_rise;
  logic          run_eff;
  logic          commute;
  logic          wr;
  logic [5:0]    pat;
  logic [15:0]   diag;
  logic [3:0]    flt_clr;
  logic [PW-1:0] delta;

  always_comb begin
    sck      = st.sa[1];
    ser_in      = st.sa[3];
    stb_n    = st.sa[5];
    ctl      = st.sb[1];
    zc       = st.sb[3];
    trip     = st.sb[5];
    flt      = st.s2f;
    sck_rise = sck & ~st.sck_d;
    sck_fall = ~sck & st.sck_d;
    stb_fall = ~stb_n & st.stb_d;
    stb_rise = stb_n & ~st.stb_d;
    run_eff  = st.run & (~st.ext_en | (st.demand != '0));
    commute  = run_eff & ~st.brake & (st.timer >= st.period);
    wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~st.ack;
    delta    = st.period >> 4;
    diag     = {(|st.flt_lat), st.flt_lat, st.comm, (st.off_cnt != '0), 7'h00};
    flt_clr  = '0;
    pat      = gate_pat(st.comm);
    next_st  = st;

    // Pins cross into the clock domain through two flops each
    next_st.sa  = {st.sa[4], ser_strobe_n_i, st.sa[2], ser_in_i, st.sa[0], ser_clk_i};
    next_st.sb  = {st.sb[4], ilim_trip_i, st.sb[2], zero_cross_i, st.sb[0], ctl_in_i};
    next_st.s1f = fault_i;
    next_st.s2f = st.s1f;
    next_st.sck_d = sck;
    next_st.zc_d  = zc;
    next_st.ctl_d = ctl;
    next_st.stb_d = stb_n;

    // Control input: high time per period becomes the demand
    if (ctl & ~st.ctl_d) begin
      next_st.demand  = st.ctl_hi;
      next_st.ctl_cnt = '0;
      next_st.ctl_hi  = '0;
    end else if (&st.ctl_cnt) begin
      // A dead input means no demand rather than a stale one
      next_st.demand = '0;
    end else begin
      next_st.ctl_cnt = st.ctl_cnt + 1'b1;
      if (ctl) begin
        next_st.ctl_hi = st.ctl_hi + 1'b1;
      end
    end

    // Wishbone slave, one wait state
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    case (wb_adr_i)
      `BCS_ADDR_CTRL:    next_st.rdat = {21'h0, st.ext_en, st.ilim, st.opm, st.spd_mode,
                                         st.dir, st.brake, st.run};
      `BCS_ADDR_PERIOD:  next_st.rdat = {{(32-PW){1'b0}}, st.period_sw};
      `BCS_ADDR_STATUS:  next_st.rdat = {13'h0, st.comm, diag};
      `BCS_ADDR_SERWORD: next_st.rdat = {16'h0, st.ser_word};
      default:           next_st.rdat = 32'h0000_0000;
    endcase
    if (wr && wb_adr_i == `BCS_ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        next_st.run      = wb_dat_i[`BCS_CTRL_RUN];
        next_st.brake    = wb_dat_i[`BCS_CTRL_BRAKE];
        next_st.dir      = wb_dat_i[`BCS_CTRL_DIR];
        next_st.spd_mode = wb_dat_i[`BCS_CTRL_SPDMODE];
        next_st.opm      = wb_dat_i[`BCS_CTRL_OPM_LO +: 2];
        next_st.ilim[1:0] = wb_dat_i[`BCS_CTRL_ILIM_LO +: 2];
      end
      if (wb_sel_i[1]) begin
        next_st.ilim[3:2] = wb_dat_i[`BCS_CTRL_ILIM_LO + 2 +: 2];
        next_st.ext_en    = wb_dat_i[`BCS_CTRL_EXTEN];
      end
    end
    if (wr && wb_adr_i == `BCS_ADDR_PERIOD) begin
      if (wb_sel_i[0]) begin
        next_st.period_sw[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        next_st.period_sw[PW-1:8] = wb_dat_i[PW-1:8];
      end
    end
    if (wr && wb_adr_i == `BCS_ADDR_STATUS && wb_sel_i[1]) begin
      flt_clr = wb_dat_i[14:11];
    end

    // Serial port: ignored entirely while the strobe is high
    if (stb_n) begin
      next_st.sdo_oe = 1'b0;
      next_st.bits   = '0;
    end
    if (stb_fall) begin
      next_st.sdo_oe = 1'b1;
      next_st.ser_out    = diag[15];
      next_st.tx     = {diag[14:0], 1'b0};
      next_st.bits   = '0;
    end else if (~stb_n) begin
      if (sck_rise) begin
        next_st.rx = {st.rx[14:0], ser_in};
        if (st.bits != 5'd31) begin
          next_st.bits = st.bits + 1'b1;
        end
      end
      if (sck_fall) begin
        next_st.ser_out = st.tx[15];
        next_st.tx  = {st.tx[14:0], 1'b0};
      end
    end
    // Only a whole word is acted on; short or long frames are dropped
    if (stb_rise && st.bits == 5'd16) begin
      next_st.ser_word = st.rx;
      flt_clr          = flt_clr | st.flt_lat;
      if (st.rx[`BCS_SER_WR]) begin
        next_st.spd_mode = st.rx[`BCS_SER_SPDMODE];
        next_st.opm      = st.rx[`BCS_SER_OPM_LO +: 2];
        next_st.ilim     = st.rx[`BCS_SER_ILIM_LO +: 4];
      end
    end

    // Latched faults; a new fault wins over a clear in the same cycle
    next_st.flt_lat = (st.flt_lat & ~flt_clr) | flt;
    next_st.flt_oe  = |next_st.flt_lat;

    // Current limiter: fixed off time after each trip
    if (trip && st.off_cnt == '0) begin
      next_st.off_cnt = OFF_CYC;
    end else if (st.off_cnt != '0) begin
      next_st.off_cnt = st.off_cnt - 1'b1;
    end

    // Commutation timer and position estimator
    if (!run_eff || st.brake) begin
      next_st.timer   = '0;
      next_st.period  = st.period_sw;
      next_st.zc_seen = 1'b0;
    end else if (commute) begin
      next_st.timer   = '0;
      next_st.zc_seen = 1'b0;
      next_st.comm    = step(st.comm, st.dir);
      if (!st.zc_seen && (st.period + delta) > st.period) begin
        next_st.period = st.period + delta;
      end
      if (next_st.comm == BCS_S1) begin
        next_st.elec_cycle_pulse = 1'b1;
      end
      if (next_st.comm == BCS_S4) begin
        next_st.elec_cycle_pulse = 1'b0;
      end
      next_st.commutation_square = 1'b0;
    end else begin
      next_st.timer = st.timer + 1'b1;
      if (st.timer == (st.period >> 1)) begin
        next_st.commutation_square = 1'b1;
      end
      if (zc & ~st.zc_d & ~st.zc_seen) begin
        next_st.zc_seen = 1'b1;
        // Early crossing means the rotor leads the estimate: speed up
        if (st.timer < (st.period >> 1) && delta != '0) begin
          next_st.period = st.period - delta;
        end
      end
    end

    // Gate drive: coast, brake or run pattern
    if (!st.run) begin
      next_st.hg = 3'b111;
      next_st.lg = 3'b000;
    end else if (st.brake) begin
      next_st.hg = 3'b111;
      next_st.lg = 3'b111;
    end else if (!run_eff) begin
      next_st.hg = 3'b111;
      next_st.lg = 3'b000;
    end else begin
      // High sides stay off during the limiter off time
      next_st.hg = ~(pat[5:3] & {3{st.off_cnt == '0}});
      next_st.lg = pat[2:0];
    end

    // Open-drain speed output; enable pulls the line low
    next_st.spd_oe = st.spd_mode ? ~st.commutation_square
                                 : ~st.elec_cycle_pulse;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st           <= '0;
      st.comm      <= BCS_S1;
      st.period_sw <= PW'(`BCS_RST_PERIOD);
      st.period    <= PW'(`BCS_RST_PERIOD);
      st.ilim      <= `BCS_RST_ILIM;
      st.spd_mode  <= 1'b0;
      st.hg        <= 3'b111;
      st.spd_oe    <= 1'b1;
      // Idle link levels: strobe and clock high, so no false edge follows reset
      st.sa        <= 6'b110_011;
      st.sck_d     <= 1'b1;
      st.stb_d     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o         = st.rdat;
  assign wb_ack_o         = st.ack;
  assign ser_out_o        = st.ser_out;
  assign ser_out_oe_o     = st.sdo_oe;
  assign high_gate_a_o    = st.hg[2];
  assign high_gate_b_o    = st.hg[1];
  assign high_gate_c_o    = st.hg[0];
  assign low_gate_a_o     = st.lg[2];
  assign low_gate_b_o     = st.lg[1];
  assign low_gate_c_o     = st.lg[0];
  assign speed_out_o      = 1'b0;
  assign speed_out_oe_o   = st.spd_oe;
  assign fault_out_n_o    = 1'b0;
  assign fault_out_n_oe_o = st.flt_oe;
  assign ilim_level_o     = st.ilim;
  assign op_mode_o        = st.opm;
  assign demand_o         = st.demand;
endmodule

// ### tb/bcs_host.sv
// Serial host model framing 16-bit words into the sequencer
module bcs_host (
  input  wire logic clk_i,
  input  wire logic ser_out_o,
  input  wire logic ser_out_oe_o,
  output logic      ser_clk_o,
  output logic      ser_in_o,
  output logic      ser_strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_clk_o = 1'b1;
    ser_in_o = 1'b0;
    ser_strobe_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Four system clocks per half period give the 320 ns link clock
  task automatic xfer(input logic [15:0] w, input int n, output logic b15);
    tick(1);
    ser_strobe_n_o <= 1'b0;
    tick(8);
    b15 = ser_out_oe_o ? ser_out_o : 1'bz;
    for (int i = 0; i < n; i++) begin
      ser_clk_o <= 1'b0;
      ser_in_o <= w[15-i];
      tick(4);
      ser_clk_o <= 1'b1;
      tick(4);
    end
    ser_strobe_n_o <= 1'b1;
    // Data is meaningless outside a frame, so never leave the last bit standing
    ser_in_o <= ~ser_in_o;
    tick(8);
  endtask
  // Wiggle clock and data with the strobe high; ends with the clock high
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      ser_clk_o <= ~ser_clk_o;
      ser_in_o <= ~ser_in_o;
      tick(4);
    end
  endtask
endmodule

// ### tb/bcs_props.sv
// Port-level assertions for the commutation sequencer
module bcs_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        ser_strobe_n_i,
  input wire logic        ser_out_o,
  input wire logic        ser_out_oe_o,
  input wire logic [3:0]  fault_i,
  input wire logic        high_gate_a_o,
  input wire logic        high_gate_b_o,
  input wire logic        high_gate_c_o,
  input wire logic        low_gate_a_o,
  input wire logic        low_gate_b_o,
  input wire logic        low_gate_c_o,
  input wire logic        speed_out_o,
  input wire logic        fault_out_n_o,
  input wire logic        fault_out_n_oe_o
);
  logic [2:0] hs;
  logic [2:0] ls;
  logic       ctl_wr;
  // Both as "gate on" masks, so the polarities compare directly
  assign hs = ~{high_gate_a_o, high_gate_b_o, high_gate_c_o};
  assign ls = {low_gate_a_o, low_gate_b_o, low_gate_c_o};
  assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 4'h0 && wb_sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_NO_SHOOT: assert property ((hs & ls) == 3'h0)
    else $error("phase driven high and low together");
  AST_ONE_HIGH: assert property ($countones(hs) <= 1)
    else $error("more than one high side on");
  AST_RUN_PAIR: assert property (hs != 3'h0 |-> $countones(ls) == 1)
    else $error("run state without exactly one low side");
  AST_COAST: assert property (ctl_wr && !wb_dat_i[0] |-> ##[1:4] (hs == 3'h0 && ls == 3'h0))
    else $error("coast did not float all phases");
  AST_BRAKE: assert property (ctl_wr && wb_dat_i[1:0] == 2'h3 |-> ##[1:4] (hs == 3'h0 && ls == 3'h7))
    else $error("brake did not turn all low sides on");
  AST_OPEN_DRAIN: assert property (speed_out_o == 1'b0 && fault_out_n_o == 1'b0)
    else $error("open drain pin drives high");
  AST_FAULT_FLAG: assert property ($rose(|fault_i) |-> ##[1:6] fault_out_n_oe_o)
    else $error("fault not flagged");
  AST_SER_IDLE: assert property (ser_strobe_n_i [*7] |-> !ser_out_oe_o)
    else $error("serial output driven with strobe high");
  AST_SER_START: assert property ($fell(ser_strobe_n_i) |-> ##[1:6] ser_out_oe_o)
    else $error("serial output not driven after strobe fall");
  AST_SER_BIT15: assert property ($rose(ser_out_oe_o) |-> ser_out_o == fault_out_n_oe_o)
    else $error("first serial bit is not the fault summary");
  cover property (hs == 3'h0 && ls == 3'h7);
  cover property ($fell(ser_strobe_n_i));
  cover property ($rose(fault_out_n_oe_o));
endmodule
bind bcs_top bcs_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .ser_strobe_n_i, .ser_out_o, .ser_out_oe_o, .fault_i,
  .high_gate_a_o, .high_gate_b_o, .high_gate_c_o, .low_gate_a_o, .low_gate_b_o,
  .low_gate_c_o, .speed_out_o, .fault_out_n_o, .fault_out_n_oe_o);

// ### tb/bcs_top_tb_top.sv
// Self-checking bench for the commutation sequencer
`include "bcs_map.svh"
module bcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] HI [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4};
  localparam logic [2:0] LO [6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF, fault_i = 4'h0, ilim_level_o;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic        wb_ack_o, ser_clk_i, ser_in_i, ser_strobe_n_i, ser_out_o, ser_out_oe_o;
  logic        high_gate_a_o, high_gate_b_o, high_gate_c_o, low_gate_a_o, low_gate_b_o;
  logic        low_gate_c_o, speed_out_o, speed_out_oe_o, fault_out_n_o, fault_out_n_oe_o;
  logic [1:0]  op_mode_o;
  logic [5:0]  gv;
  logic        b, hi_seen;
  int          err_count = 0, check_count = 0, k;
  assign gv = {high_gate_a_o, high_gate_b_o, high_gate_c_o, low_gate_a_o, low_gate_b_o,
               low_gate_c_o};
  bcs_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ser_clk_i, .ser_in_i, .ser_strobe_n_i, .ser_out_o,
    .ser_out_oe_o, .ctl_in_i(1'b0), .zero_cross_i(1'b0), .ilim_trip_i(1'b0), .fault_i,
    .high_gate_a_o, .high_gate_b_o, .high_gate_c_o, .low_gate_a_o, .low_gate_b_o,
    .low_gate_c_o, .speed_out_o, .speed_out_oe_o, .fault_out_n_o, .fault_out_n_oe_o,
    .ilim_level_o, .op_mode_o, .demand_o());
  bcs_host u_host (.clk_i, .ser_out_o, .ser_out_oe_o, .ser_clk_o(ser_clk_i),
    .ser_in_o(ser_in_i), .ser_strobe_n_o(ser_strobe_n_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Request stands until the rising edge that samples ack; data is taken at that edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic step(input int s);
    logic [5:0] old;
    old = gv;
    hi_seen = 1'b0;
    for (int n = 0; n < 400 && gv === old; n++) begin
      @(posedge clk_i);
      if (speed_out_oe_o === 1'b0) hi_seen = 1'b1;
    end
    repeat (2) @(posedge clk_i);
    chk(gv, {~HI[s], LO[s]}, "gates");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(gv, 6'h38, "reset gates");
    chk({speed_out_oe_o, fault_out_n_oe_o, ser_out_oe_o}, 3'h4, "reset pins");
    wb(1'b0, `BCS_ADDR_PERIOD, 32'h0000_0000);
    chk(rd, 32'h0000_1000, "period");
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
    // Short period keeps a dozen commutations brief
    wb(1'b1, `BCS_ADDR_PERIOD, 32'h0000_0040);
    wb(1'b1, `BCS_ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(gv, {~HI[0], LO[0]}, "first state");
    k = 0;
    for (int i = 0; i < 12; i++) begin
      k = i < 6 ? (k + 1) % 6 : (k + 5) % 6;
      if (i == 6) wb(1'b1, `BCS_ADDR_CTRL, 32'h0000_0005);
      step(k);
      // The run starts in state 1 without entering it, so the pulse stays low until it does
      chk(!speed_out_oe_o, i < 6 ? (k < 3 && i > 1) : (k == 0 || k > 3), "cycle pulse");
    end
    u_host.xfer(16'hE500, 16, b);
    chk(ilim_level_o, 4'h5, "limit");
    chk(op_mode_o, 2'h2, "op mode");
    wb(1'b0, `BCS_ADDR_SERWORD, 32'h0000_0000);
    chk(rd, 32'h0000_E500, "word");
    wb(1'b0, `BCS_ADDR_STATUS, 32'h0000_0000);
    k = rd[18:16];
    for (int i = 0; i < 2; i++) begin
      k = (k + 5) % 6;
      step(k);
      chk(speed_out_oe_o, 1'b1, "square falls");
      if (i == 1) chk(hi_seen, 1'b1, "square high");
    end
    u_host.xfer(16'h8F00, 15, b);
    u_host.noise();
    chk(ilim_level_o, 4'h5, "short frame");
    wb(1'b0, `BCS_ADDR_SERWORD, 32'h0000_0000);
    chk(rd, 32'h0000_E500, "word kept");
    wb(1'b1, `BCS_ADDR_CTRL, 32'h0000_0006);
    repeat (4) @(posedge clk_i);
    chk(gv, 6'h38, "coast");
    wb(1'b1, `BCS_ADDR_CTRL, 32'h0000_0003);
    repeat (200) @(posedge clk_i);
    chk(gv, 6'h3F, "brake");
    fault_i <= 4'h2;
    repeat (6) @(posedge clk_i);
    chk(fault_out_n_oe_o, 1'b1, "fault pin");
    wb(1'b0, `BCS_ADDR_STATUS, 32'h0000_0000);
    chk(rd[15:11], 5'h12, "diag");
    fault_i <= 4'h0;
    u_host.xfer(16'h0000, 16, b);
    chk(b, 1'b1, "fault bit out");
    repeat (4) @(posedge clk_i);
    chk(fault_out_n_oe_o, 1'b0, "fault cleared");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule
